/* shared/timer_map_map.vh */
/*
 * register map, field positions, reset values and timing counts of the
 * dual timer/counter with external interrupt flags.
 * assumes: included by bare name from the rtl files; definitions only.
 */
`ifndef TIMER_MAP_MAP_VH
`define TIMER_MAP_MAP_VH

// ****************************************
// register bus
// ****************************************
`define ADDR_W 3
`define DATA_W 8
`define A_TCS 3'h0
`define A_MODE_REG 3'h1
`define A_TL0 3'h2
`define A_TH0 3'h3
`define A_TL1 3'h4
`define A_TH1 3'h5
`define A_IRQ_STAT 3'h6
`define A_IRQ_MASK 3'h7
`define RDATA_IDLE 8'h00

// ****************************************
// reset values
// ****************************************
`define TCS_RST 8'h00
`define MODE_REG_RST 8'h00
`define CNT_RST 8'h00
`define IRQ_RST 4'h0
`define SYNC_IDLE 2'h3

// ****************************************
// timer_control_status fields (channel 0; channel 1 is +TCS_STRIDE)
// ****************************************
`define TCS_STRIDE 2
`define TCS_OVF 5
`define TCS_RUN 4
`define TCS_EDGE_FLAG 1
`define TCS_TYPE 0

// ****************************************
// timer_mode_register fields (channel 0 low nibble, channel 1 high)
// ****************************************
`define MODE_STRIDE 4
`define MODE_GATE 3
`define MODE_CSEL 2
`define MODE_CODE_HI 1
`define MODE_CODE_LO 0

// ****************************************
// mode codes
// ****************************************
`define MODE_13 2'h0
`define MODE_16 2'h1
`define MODE_8R 2'h2
`define M13_LOW_W 5
`define M13_ZERO 3'h0

// ****************************************
// interrupt status / mask / request layout
// ****************************************
`define IRQ_W 4
`define IS_EXT0 0
`define IS_OVF 1
`define IS_STRIDE 2

// ****************************************
// timing: one machine cycle is 12 processor clocks
// ****************************************
`define MC_CLKS 12
`define MC_CNT_W 4
`define MC_LAST 4'hb
`define MC_ZERO 4'h0
`define MC_ONE 4'h1

`endif

/* rtl/timer_unit.v */
/*
 * one timer/counter: low and high count bytes, the three counting modes
 * and the overflow pulse.
 * assumes: inc_i is a one-cycle pulse on clk_i; byte writes come from the
 * register slave on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "timer_map_map.vh"

module timer_unit (
	// clock and reset
	input wire clk_i,
	input wire rst_b_i,
	// counting
	input wire inc_i,
	input wire [1:0] mode_i,
	// software access to the count bytes
	input wire low_we_i,
	input wire high_we_i,
	input wire [7:0] wdata_i,
	// state
	output reg [7:0] low_o,
	output reg [7:0] high_o,
	output wire ovf_o
);

	reg [7:0] next_low;
	reg [7:0] next_high;
	wire all13;
	wire all16;
	wire all8;
	reg wrap;

	// wrap detection per mode, all ones about to wrap to zero (or to the reload byte in 8-bit reload mode)
	assign all13 = &{high_o, low_o[`M13_LOW_W-1:0]};
	assign all16 = &{high_o, low_o};
	assign all8 = &low_o;

	always @* begin
		case (mode_i)
			`MODE_13: wrap = all13;
			`MODE_16: wrap = all16;
			`MODE_8R: wrap = all8;
			default: wrap = 1'b0;
		endcase
	end

	// overflow pulses in the cycle the count wraps
	assign ovf_o = inc_i & wrap;

	// next count; a software byte write wins over an increment
	always @* begin
		next_low = low_o;
		next_high = high_o;
		if (inc_i) begin
			case (mode_i)
				`MODE_13: begin
					{next_high, next_low[`M13_LOW_W-1:0]} =
						{high_o, low_o[`M13_LOW_W-1:0]} + 13'h0001;
				end
				`MODE_16: begin
					{next_high, next_low} = {high_o, low_o} + 16'h0001;
				end
				`MODE_8R: begin
					next_low = all8 ? high_o : low_o + 8'h01;
				end
				default: begin
					next_low = low_o; // mode 3 holds the count
				end
			endcase
		end
		if (low_we_i) begin
			next_low = wdata_i;
		end
		if (high_we_i) begin
			next_high = wdata_i;
		end
		if (mode_i == `MODE_13) begin
			next_low[7:`M13_LOW_W] = `M13_ZERO;
		end
	end

	// count bytes
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			low_o <= `CNT_RST;
			high_o <= `CNT_RST;
		end else begin
			low_o <= next_low;
			high_o <= next_high;
		end
	end

endmodule
`default_nettype wire

/* rtl/dual_timer_counter_ext_int.v */
/*
 * two timer/counters with a shared control/status register, a mode
 * register, external interrupt edge/level flags, a sticky interrupt
 * status register with mask, and a plain register port.
 * assumes: one 20 MHz processor clock; pins are asynchronous and are
 * synchronised here; service acknowledge pulses come from the interrupt
 * controller on the same clock.
 */
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_map_map.vh"

module dual_timer_counter_ext_int (
	// clock and reset
	input wire clk_i,
	input wire rst_b_i,
	// register port
	input wire [`ADDR_W-1:0] addr_i,
	input wire [`DATA_W-1:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [`DATA_W-1:0] rdata_o,
	// pins
	input wire count_input_a_i,
	input wire count_input_b_i,
	input wire ext_irq_pin_a_i,
	input wire ext_irq_pin_b_i,
	// interrupt controller
	input wire [`IRQ_W-1:0] service_ack_i,
	output wire [`IRQ_W-1:0] irq_req_o,
	output wire irq_o
);

	// ****************************************
	// declarations
	// ****************************************
	reg [7:0] timer_control_status;
	reg [7:0] timer_mode_register;
	reg [`IRQ_W-1:0] irq_status;
	reg [`IRQ_W-1:0] irq_mask;
	reg [7:0] next_tcs;
	reg [`IRQ_W-1:0] next_status;
	reg [`MC_CNT_W-1:0] mc_cnt;
	reg [1:0] cnt_s1;
	reg [1:0] cnt_s2;
	reg [1:0] cnt_smp;
	reg [1:0] ext_s1;
	reg [1:0] ext_s2;
	reg [1:0] ext_smp;
	wire mc_tick;
	wire [1:0] cnt_pin;
	wire [1:0] ext_pin;
	wire [1:0] cnt_fall;
	wire [1:0] ext_fall;
	wire [1:0] inc;
	wire [1:0] ovf;
	wire [1:0] ext_set;
	wire [1:0] edge_mode;
	wire [7:0] cnt_low [0:1];
	wire [7:0] cnt_high [0:1];
	wire [`IRQ_W-1:0] events;
	wire tcs_we;
	integer k;

	assign cnt_pin = {count_input_b_i, count_input_a_i};
	assign ext_pin = {ext_irq_pin_b_i, ext_irq_pin_a_i};
	assign tcs_we = wr_i & (addr_i == `A_TCS);

	// ****************************************
	// machine cycle prescaler
	// ****************************************

	// one tick every 12 processor clocks
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mc_cnt <= `MC_ZERO;
		end else if (mc_tick) begin
			mc_cnt <= `MC_ZERO;
		end else begin
			mc_cnt <= mc_cnt + `MC_ONE;
		end
	end

	assign mc_tick = (mc_cnt == `MC_LAST);

	// ****************************************
	// pin synchronisers and machine-cycle sampling
	// ****************************************

	// two flops per pin before any logic looks at it
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_s1 <= `SYNC_IDLE;
			cnt_s2 <= `SYNC_IDLE;
			ext_s1 <= `SYNC_IDLE;
			ext_s2 <= `SYNC_IDLE;
		end else begin
			cnt_s1 <= cnt_pin;
			cnt_s2 <= cnt_s1;
			ext_s1 <= ext_pin;
			ext_s2 <= ext_s1;
		end
	end

	// levels held from the previous machine cycle
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_smp <= `SYNC_IDLE;
			ext_smp <= `SYNC_IDLE;
		end else if (mc_tick) begin
			cnt_smp <= cnt_s2;
			ext_smp <= ext_s2;
		end
	end

	// ****************************************
	// per-timer counting logic
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : chan
			wire [3:0] tm;
			wire gate_ok;
			wire use_pin;
			wire run;
			wire [`ADDR_W-1:0] a_lo;
			wire [`ADDR_W-1:0] a_hi;

			assign tm = timer_mode_register[`MODE_STRIDE*i +: `MODE_STRIDE];
			assign a_lo = (i == 0) ? `A_TL0 : `A_TL1;
			assign a_hi = (i == 0) ? `A_TH0 : `A_TH1;

			// high in one sample, low in the next: a 1-to-0 event
			assign cnt_fall[i] = mc_tick & cnt_smp[i] & ~cnt_s2[i];
			assign ext_fall[i] = mc_tick & ext_smp[i] & ~ext_s2[i];

			// gate lets the timer run only while its interrupt pin is high
			assign gate_ok = ~tm[`MODE_GATE] | ext_s2[i];
			// counter operation, or gated operation, counts pin edges
			assign use_pin = tm[`MODE_CSEL] | tm[`MODE_GATE];
			assign run = timer_control_status[`TCS_RUN + `TCS_STRIDE*i];
			assign inc[i] = run & gate_ok & (use_pin ? cnt_fall[i] : mc_tick);

			// edge flag mode per channel
			assign edge_mode[i] = timer_control_status[`TCS_TYPE + `TCS_STRIDE*i];
			// edge mode requests on a fall, level mode while the pin is low
			assign ext_set[i] = edge_mode[i] ? ext_fall[i] : ~ext_s2[i];

			timer_unit u_timer (
				.clk_i(clk_i),
				.rst_b_i(rst_b_i),
				.inc_i(inc[i]),
				.mode_i(tm[`MODE_CODE_HI:`MODE_CODE_LO]),
				.low_we_i(wr_i & (addr_i == a_lo)),
				.high_we_i(wr_i & (addr_i == a_hi)),
				.wdata_i(wdata_i),
				.low_o(cnt_low[i]),
				.high_o(cnt_high[i]),
				.ovf_o(ovf[i])
			);
		end
	endgenerate

	// ****************************************
	// timer_control_status register
	// ****************************************

	// software write, then service clears, then hardware sets win
	always @* begin
		next_tcs = timer_control_status;
		if (tcs_we) begin
			next_tcs = wdata_i;
		end
		for (k = 0; k < 2; k = k + 1) begin
			if (service_ack_i[`IS_OVF + `IS_STRIDE*k]) begin
				next_tcs[`TCS_OVF + `TCS_STRIDE*k] = 1'b0;
			end
			if (ovf[k]) begin
				next_tcs[`TCS_OVF + `TCS_STRIDE*k] = 1'b1;
			end
			if (edge_mode[k]) begin
				if (service_ack_i[`IS_EXT0 + `IS_STRIDE*k]) begin
					next_tcs[`TCS_EDGE_FLAG + `TCS_STRIDE*k] = 1'b0;
				end
				if (ext_fall[k]) begin
					next_tcs[`TCS_EDGE_FLAG + `TCS_STRIDE*k] = 1'b1;
				end
			end else begin
				next_tcs[`TCS_EDGE_FLAG + `TCS_STRIDE*k] = ~ext_s2[k];
			end
		end
	end

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			timer_control_status <= `TCS_RST;
		end else begin
			timer_control_status <= next_tcs;
		end
	end

	// ****************************************
	// timer_mode_register
	// ****************************************

	// plain software register
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			timer_mode_register <= `MODE_REG_RST;
		end else if (wr_i && (addr_i == `A_MODE_REG)) begin
			timer_mode_register <= wdata_i;
		end
	end

	// ****************************************
	// sticky interrupt status and mask
	// ****************************************

	// events in request order: ext a, timer 0, ext b, timer 1
	assign events = {ovf[1], ext_set[1], ovf[0], ext_set[0]};

	// write one to clear; an event in the same cycle wins
	always @* begin
		next_status = irq_status;
		if (wr_i && (addr_i == `A_IRQ_STAT)) begin
			next_status = irq_status & ~wdata_i[`IRQ_W-1:0];
		end
		next_status = next_status | events;
	end

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_status <= `IRQ_RST;
			irq_mask <= `IRQ_RST;
		end else begin
			irq_status <= next_status;
			if (wr_i && (addr_i == `A_IRQ_MASK)) begin
				irq_mask <= wdata_i[`IRQ_W-1:0];
			end
		end
	end

	// level interrupt while any unmasked status bit is set
	assign irq_o = |(irq_status & irq_mask);

	// raw flag requests to the interrupt controller
	assign irq_req_o = {
		timer_control_status[`TCS_OVF + `TCS_STRIDE],
		timer_control_status[`TCS_EDGE_FLAG + `TCS_STRIDE],
		timer_control_status[`TCS_OVF],
		timer_control_status[`TCS_EDGE_FLAG]
	};

	// ****************************************
	// read port
	// ****************************************

	// read data stand for one cycle after the strobe, zero otherwise
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= `RDATA_IDLE;
		end else if (rd_i) begin
			case (addr_i)
				`A_TCS: rdata_o <= timer_control_status;
				`A_MODE_REG: rdata_o <= timer_mode_register;
				`A_TL0: rdata_o <= cnt_low[0];
				`A_TH0: rdata_o <= cnt_high[0];
				`A_TL1: rdata_o <= cnt_low[1];
				`A_TH1: rdata_o <= cnt_high[1];
				`A_IRQ_STAT: rdata_o <= {{(`DATA_W-`IRQ_W){1'b0}}, irq_status};
				`A_IRQ_MASK: rdata_o <= {{(`DATA_W-`IRQ_W){1'b0}}, irq_mask};
				default: rdata_o <= `RDATA_IDLE;
			endcase
		end else begin
			rdata_o <= `RDATA_IDLE;
		end
	end

endmodule
`default_nettype wire

/* tb/dual_timer_counter_ext_int_props.sv */
/* port checker for the dual timer/counter block.
 * assumes: bound to the top module; one clock, async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
`include "timer_map_map.vh"

// ********
// checker
// ********
module timer_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// pins
	input wire logic count_input_a_i,
	input wire logic count_input_b_i,
	input wire logic ext_irq_pin_a_i,
	input wire logic ext_irq_pin_b_i,
	// interrupts
	input wire logic [3:0] service_ack_i,
	input wire logic [3:0] irq_req_o,
	input wire logic irq_o
);
	reg [7:0] ctl;
	reg [7:0] msk;
	wire ctl_wr;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// a software write to the control register this cycle
	assign ctl_wr = wr_i && addr_i == `A_TCS;
	// shadow of what software wrote
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctl <= 8'h00;
			msk <= 8'h00;
		end else if (wr_i) begin
			if (addr_i == `A_TCS)
				ctl <= wdata_i;
			if (addr_i == `A_IRQ_MASK)
				msk <= wdata_i;
		end
	end
	a_read_runbits: assert property (rd_i && addr_i == `A_TCS |=>
		(rdata_o & 8'h55) == ($past(ctl) & 8'h55)) else $error("run or type bits read wrong");
	a_read_flags: assert property (rd_i && addr_i == `A_TCS |=>
		{rdata_o[7], rdata_o[3], rdata_o[5], rdata_o[1]} == $past(irq_req_o))
		else $error("flag bits differ from requests");
	a_stop_no_flag: assert property (!ctl[4] && !irq_req_o[1] && !ctl_wr |=>
		!irq_req_o[1]) else $error("stopped timer set its flag");
	a_flag_ack: assert property (service_ack_i[1] && !ctl[4] && !ctl_wr |=>
		!irq_req_o[1]) else $error("service did not clear flag");
	a_edge_sticky: assert property (ctl[2] && irq_req_o[2] && !service_ack_i[2] && !ctl_wr
		|=> irq_req_o[2]) else $error("edge flag lost");
	a_edge_ack: assert property (ext_irq_pin_a_i [*8] ##0 (ctl[0] && service_ack_i[0]
		&& !ctl_wr) |=> !irq_req_o[0]) else $error("service did not clear edge flag");
	a_level_low: assert property ((!ctl[0] && !ext_irq_pin_a_i) [*6] |->
		irq_req_o[0]) else $error("low level not requesting");
	a_irq_masked: assert property (irq_o |-> msk[3:0] != 4'h0) else $error("irq while all masked");
endmodule

bind dual_timer_counter_ext_int timer_props u_props (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .rdata_o, .count_input_a_i, .count_input_b_i, .ext_irq_pin_a_i, .ext_irq_pin_b_i,
	.service_ack_i, .irq_req_o, .irq_o);
`default_nettype wire

/* tb/pin_source.sv */
/* model of the pins: count inputs and external interrupt pins.
 * assumes: driven from the bench's clock; pins idle high. */
`timescale 1ns/1ps
`default_nettype none

// ********
// pin model
// ********
module pin_source (
	// clock
	input wire logic clk_i,
	// pins
	output logic count_a_o,
	output logic count_b_o,
	output logic irq_a_o,
	output logic irq_b_o
);
	logic [3:0] lvl = 4'hf;
	// pin levels
	assign {irq_b_o, irq_a_o, count_b_o, count_a_o} = lvl;
	// one pin changes right after an edge
	task set_pin(input int idx, input logic v);
		@(posedge clk_i);
		lvl[idx] <= v;
	endtask
	// n falling edges, every level held 15 clocks
	task pulse(input int idx, input int n);
		repeat (n) begin
			repeat (14) @(posedge clk_i);
			set_pin(idx, 1'b0);
			repeat (14) @(posedge clk_i);
			set_pin(idx, 1'b1);
		end
	endtask
endmodule
`default_nettype wire

/* tb/tb_dual_timer_counter_ext_int.sv */
/* self-checking bench for the dual timer/counter block.
 * assumes: 20 MHz clock; pins come from the pin model. */
`timescale 1ns/1ps
`default_nettype none
`include "timer_map_map.vh"

module tb_dual_timer_counter_ext_int;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [3:0] service_ack_i = 4'h0;
	wire [7:0] rdata_o;
	wire [3:0] irq_req_o;
	wire irq_o;
	wire cnt_a;
	wire cnt_b;
	wire pin_a;
	wire pin_b;
	logic [7:0] d;
	logic [7:0] m;
	int fails = 0;
	int checked = 0;
	int cycles = 0;

	// ********
	// clock, model and design
	// ********
	always #25 clk_i = ~clk_i;
	pin_source pins (.clk_i(clk_i), .count_a_o(cnt_a), .count_b_o(cnt_b), .irq_a_o(pin_a),
		.irq_b_o(pin_b));
	dual_timer_counter_ext_int DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.count_input_a_i(cnt_a), .count_input_b_i(cnt_b), .ext_irq_pin_a_i(pin_a),
		.ext_irq_pin_b_i(pin_b), .service_ack_i(service_ack_i), .irq_req_o(irq_req_o),
		.irq_o(irq_o));

	// ********
	// tasks
	// ********
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task results;
		if (fails == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask
	task ack(input logic [3:0] v);
		@(posedge clk_i);
		service_ack_i <= v;
		@(posedge clk_i);
		service_ack_i <= 4'h0;
	endtask
	// run one timer for t machine cycles exactly, then stop and check it
	task run(input logic [2:0] la, input logic [7:0] md, input logic [7:0] tl,
		input logic [7:0] th, input logic [7:0] rb, input int t, input logic [7:0] etl,
		input logic [7:0] eth, input logic [7:0] ef);
		wr(`A_MODE_REG, md);
		wr(la, tl);
		wr(la + 3'h1, th);
		wr(`A_TCS, rb);
		repeat (12 * t - 2) @(posedge clk_i);
		#1 d = {4'h0, irq_req_o};
		wr(`A_TCS, 8'h00);
		chk(d, ef);
		rd(la, etl);
		rd(la + 3'h1, eth);
		wr(`A_IRQ_STAT, 8'h0f);
	endtask

	// ********
	// hang guard
	// ********
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			results();
		end
	end

	// ********
	// tests
	// ********
	initial begin
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (int a = 0; a < 8; a++)
			rd(3'(a), 8'h00);
		run(`A_TL0, 8'h01, 8'hfe, 8'hff, 8'h10, 3, 8'h01, 8'h00, 8'h02);
		run(`A_TL1, 8'h00, 8'hfe, 8'hff, 8'h40, 3, 8'h01, 8'h00, 8'h08);
		run(`A_TL0, 8'h02, 8'hfe, 8'ha0, 8'h10, 3, 8'ha1, 8'ha0, 8'h02);
		run(`A_TL1, 8'h10, 8'hff, 8'h00, 8'h40, 2, 8'h01, 8'h01, 8'h00);
		repeat (40) @(posedge clk_i);
		rd(`A_TL1, 8'h01);
		// mode 3 on timer 1 holds its count and never overflows
		run(`A_TL1, 8'h30, 8'h12, 8'h34, 8'h40, 2, 8'h12, 8'h34, 8'h00);
		// counting pin edges, then gating
		run(`A_TL0, 8'h05, 8'h00, 8'h00, 8'h10, 1, 8'h00, 8'h00, 8'h00);
		wr(`A_TCS, 8'h10);
		pins.pulse(0, 5);
		wr(`A_TCS, 8'h00);
		rd(`A_TL0, 8'h05);
		run(`A_TL0, 8'h09, 8'h00, 8'h00, 8'h10, 1, 8'h00, 8'h00, 8'h00);
		wr(`A_TCS, 8'h10);
		pins.set_pin(2, 1'b0);
		pins.pulse(0, 3);
		pins.set_pin(2, 1'b1);
		pins.pulse(0, 2);
		wr(`A_TCS, 8'h00);
		rd(`A_TL0, 8'h02);
		// external interrupts, level then edge, with the mask
		for (int i = 0; i < 2; i++) begin
			m = 8'(1 << (2 * i));
			wr(`A_IRQ_STAT, 8'h0f);
			pins.set_pin(2 + i, 1'b0);
			repeat (8) @(posedge clk_i);
			#1 chk({4'h0, irq_req_o}, m);
			pins.set_pin(2 + i, 1'b1);
			repeat (8) @(posedge clk_i);
			#1 chk({4'h0, irq_req_o}, 8'h00);
			wr(`A_TCS, m);
			pins.pulse(2 + i, 1);
			repeat (8) @(posedge clk_i);
			#1 chk({4'h0, irq_req_o}, m);
			ack(m[3:0]);
			#1 chk({4'h0, irq_req_o}, 8'h00);
			rd(`A_IRQ_STAT, m);
			wr(`A_IRQ_MASK, ~m);
			#1 chk({7'h0, irq_o}, 8'h00);
			wr(`A_IRQ_MASK, m);
			#1 chk({7'h0, irq_o}, 8'h01);
			wr(`A_IRQ_STAT, m);
			#1 chk({7'h0, irq_o}, 8'h00);
		end
		wr(`A_TCS, 8'ha0);
		#1 chk({4'h0, irq_req_o}, 8'h0a);
		ack(4'ha);
		#1 chk({4'h0, irq_req_o}, 8'h00);
		results();
	end
endmodule
`default_nettype wire
